// ===== dv/fsk_sfd_phr_config_bench.sv
// Self-checking bench for the FSK header config block
`default_nettype none
module fsk_sfd_phr_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_srst, i_hsel, i_hwrite, i_rx_frame_start_irq, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  fsk_hdr_pkg::rx_hdr_t i_rx_hdr;
  fsk_hdr_pkg::delim_search_t o_search;
  fsk_hdr_pkg::tx_frame_cfg_t o_tx_cfg;
  fsk_hdr_pkg::rx_frame_cfg_t o_rx_cfg;
  fsk_hdr_pkg::dirmod_cfg_t o_dirmod;
  int fails, checks;
  fsk_sfd_phr_config dut (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rx_frame_start_irq(i_rx_frame_start_irq), .i_rx_hdr(i_rx_hdr),
    .o_search(o_search), .o_tx_cfg(o_tx_cfg), .o_rx_cfg(o_rx_cfg), .o_dirmod(o_dirmod));
  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Single word transfer; waits on ready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= {24'h000000, a};
    i_htrans <= fsk_hdr_pkg::HTRANS_NONSEQ;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
    @(negedge i_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("response", 1'b0, o_hresp);
  endtask
  // One frame start pulse; header lines scrambled afterwards
  task automatic frame(input logic [5:0] h);
    @(posedge i_clk);
    i_rx_frame_start_irq <= 1'b1;
    i_rx_hdr <= h;
    @(posedge i_clk);
    i_rx_frame_start_irq <= 1'b0;
    i_rx_hdr <= ~h;
  endtask
  task automatic t_reset;
    logic [7:0] e;
    for (int i = 0; i < 17; i++) begin
      e = (i == 0) ? 8'h18 : (i == 4) ? 8'h72 : (i == 7) ? 8'h04 : 8'h00;
      rdchk("reset value", 8'(i * 4), {24'h000000, e});
    end
    chk("reset formats", 4'h2, {o_rx_cfg.fmt_delim0, o_rx_cfg.fmt_delim1});
    chk("reset search", 1'b0, o_search.wide_search);
    $display("done t_reset");
  endtask
  task automatic t_search;
    bus(1'b1, fsk_hdr_pkg::ADDR_DELIM0_LOW, 32'h11);
    bus(1'b1, fsk_hdr_pkg::ADDR_DELIM0_HIGH, 32'h22);
    bus(1'b1, fsk_hdr_pkg::ADDR_DELIM1_LOW, 32'h33);
    bus(1'b1, fsk_hdr_pkg::ADDR_DELIM1_HIGH, 32'h44);
    chk("pattern pair", 32'h44332211, {o_search.pattern1, o_search.pattern0});
    chk("wide pattern", 32'h44332211, o_search.pattern_wide);
    bus(1'b1, fsk_hdr_pkg::ADDR_FRAME_CFG, 32'h60);
    chk("search bits", 2'b11, {o_search.hard_decision, o_search.wide_search});
    bus(1'b1, fsk_hdr_pkg::ADDR_FRAME_CFG, 32'h20);
    chk("search bits", 2'b01, {o_search.hard_decision, o_search.wide_search});
    $display("done t_search");
  endtask
  task automatic t_formats;
    logic [2:0] k;
    for (k = 0; k < 4; k++) begin
      bus(1'b1, fsk_hdr_pkg::ADDR_FRAME_CFG, {27'h0, k[0], k[1:0], k[1:0]});
      chk("formats", {k[1:0], k[1:0], k[0]}, {o_rx_cfg.fmt_delim0, o_rx_cfg.fmt_delim1, o_rx_cfg.raw_msb_first});
    end
    bus(1'b1, fsk_hdr_pkg::ADDR_FRAME_CFG, 32'hFF);
    rdchk("frame cfg", fsk_hdr_pkg::ADDR_FRAME_CFG, 32'h7F);
    $display("done t_formats");
  endtask
  task automatic t_lengths;
    bus(1'b1, fsk_hdr_pkg::ADDR_PREAMBLE_HIGH, 32'hFF);
    bus(1'b1, fsk_hdr_pkg::ADDR_PREAMBLE_LOW, 32'hA5);
    chk("preamble", 10'h3A5, o_tx_cfg.preamble_len);
    rdchk("preamble high", fsk_hdr_pkg::ADDR_PREAMBLE_HIGH, 32'hC0);
    bus(1'b1, fsk_hdr_pkg::ADDR_RAW_LEN_LOW, 32'h5A);
    bus(1'b1, fsk_hdr_pkg::ADDR_RAW_LEN_HIGH, 32'hFF);
    chk("raw length", 11'h75A, o_rx_cfg.raw_rx_len);
    rdchk("raw high", fsk_hdr_pkg::ADDR_RAW_LEN_HIGH, 32'h07);
    $display("done t_lengths");
  endtask
  task automatic t_tx_hdr;
    bus(1'b1, fsk_hdr_pkg::ADDR_FRAME_CFG, 32'h09);
    bus(1'b1, fsk_hdr_pkg::ADDR_TX_HDR, 32'h0B);
    chk("tx fields", 8'hAB, {o_tx_cfg.fmt, 2'b10, o_tx_cfg.delim_select, o_tx_cfg.whitening_on,
      o_tx_cfg.reserved_hdr_bit2, o_tx_cfg.reserved_hdr_bit1});
    chk("tx pattern", 16'h4433, o_tx_cfg.delim_pattern);
    bus(1'b1, fsk_hdr_pkg::ADDR_TX_HDR, 32'h04);
    chk("tx fields", 6'h14, {o_tx_cfg.fmt, o_tx_cfg.delim_select, o_tx_cfg.whitening_on, 2'b00});
    chk("tx pattern", 16'h2211, o_tx_cfg.delim_pattern);
    $display("done t_tx_hdr");
  endtask
  task automatic t_rx_status;
    frame(6'h3F);
    rdchk("rx status", fsk_hdr_pkg::ADDR_RX_HDR, 32'hCF);
    bus(1'b1, fsk_hdr_pkg::ADDR_RX_HDR, 32'h00);
    rdchk("rx status", fsk_hdr_pkg::ADDR_RX_HDR, 32'hCF);
    frame(6'h25);
    rdchk("rx status", fsk_hdr_pkg::ADDR_RX_HDR, 32'h85);
    frame(6'h1A);
    rdchk("rx status", fsk_hdr_pkg::ADDR_RX_HDR, 32'h4A);
    $display("done t_rx_status");
  endtask
  task automatic t_dirmod;
    logic [3:0] k;
    for (k = 0; k < 8; k++) begin
      bus(1'b1, fsk_hdr_pkg::ADDR_DIRMOD, {30'h0, k[1:0]});
      // frontend bit only ever written for this FSK path
      bus(1'b1, fsk_hdr_pkg::ADDR_TX_FRONTEND, {27'h0, k[2], 4'h0});
      chk("dirmod", {k[0] & k[2], k[1] & k[0]}, {o_dirmod.dirmod_active, o_dirmod.preemph_active});
    end
    bus(1'b1, fsk_hdr_pkg::ADDR_PREEMPH0, 32'h31);
    bus(1'b1, fsk_hdr_pkg::ADDR_PREEMPH1, 32'h32);
    bus(1'b1, fsk_hdr_pkg::ADDR_PREEMPH2, 32'h33);
    chk("preemph", 24'h313233, {o_dirmod.preemph_byte0, o_dirmod.preemph_byte1, o_dirmod.preemph_byte2});
    $display("done t_dirmod");
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    i_srst = 1'b1;
    i_hsel = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = fsk_hdr_pkg::HSIZE_WORD;
    i_hwdata = 32'h0;
    i_rx_frame_start_irq = 1'b0;
    i_rx_hdr = 6'h00;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset;
    t_search;
    t_formats;
    t_lengths;
    t_tx_hdr;
    t_rx_status;
    t_dirmod;
    test_done;
  end
  // Watchdog well beyond the roughly two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire

// ===== dv/fsk_sfd_phr_config_monitor.sv
// Port checker for the FSK header config block
`default_nettype none
module fsk_sfd_phr_config_monitor (
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Sync reset
  input wire logic i_hsel, // Select
  input wire logic [31:0] i_haddr, // Address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite, // Write
  input wire logic [2:0] i_hsize, // Size
  input wire logic [31:0] i_hwdata, // Write data
  input wire logic i_hready, // Bus ready
  input wire logic [31:0] o_hrdata, // Read data
  input wire logic o_hreadyout, // Slave ready
  input wire logic o_hresp, // Response
  input wire logic i_rx_frame_start_irq, // Frame start
  input wire fsk_hdr_pkg::rx_hdr_t i_rx_hdr, // Header fields
  input wire fsk_hdr_pkg::delim_search_t o_search, // Search settings
  input wire fsk_hdr_pkg::tx_frame_cfg_t o_tx_cfg, // Transmit settings
  input wire fsk_hdr_pkg::rx_frame_cfg_t o_rx_cfg, // Receive settings
  input wire fsk_hdr_pkg::dirmod_cfg_t o_dirmod // Direct modulation
);
  logic [7:0] exp_rx_ff;
  // Expected status image, taken on every frame start
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      exp_rx_ff <= 8'h00;
    end else if (i_rx_frame_start_irq) begin
      exp_rx_ff <= {i_rx_hdr[5:4], 2'b00, i_rx_hdr[3:0]};
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // Address phase taken for one register
  sequence s_take(logic [7:0] a, logic w);
    i_hsel && i_hready && i_htrans == fsk_hdr_pkg::HTRANS_NONSEQ && i_hwrite == w &&
      i_hsize == fsk_hdr_pkg::HSIZE_WORD && i_haddr == {24'h000000, a};
  endsequence
  // Whole write: address phase then data phase
  sequence s_write(logic [7:0] a);
    s_take(a, 1'b1) ##1 1'b1;
  endsequence
  a_wide_delim_order: assert property (o_search.pattern_wide == {o_search.pattern1, o_search.pattern0})
    else $error("wide delimiter order wrong");
  a_tx_delim_pick: assert property (o_tx_cfg.delim_pattern == (o_tx_cfg.delim_select ? o_search.pattern1 : o_search.pattern0))
    else $error("transmit delimiter not the selected one");
  a_tx_fmt_pick: assert property (o_tx_cfg.fmt == (o_tx_cfg.delim_select ? o_rx_cfg.fmt_delim1 : o_rx_cfg.fmt_delim0))
    else $error("transmit format not that of the selected delimiter");
  a_raw_order_shared: assert property (o_tx_cfg.raw_msb_first == o_rx_cfg.raw_msb_first)
    else $error("raw bit order differs between directions");
  a_preamble_low_write: assert property (s_write(fsk_hdr_pkg::ADDR_PREAMBLE_LOW) |=> o_tx_cfg.preamble_len[7:0] == $past(i_hwdata[7:0]))
    else $error("preamble low byte not taken");
  a_delim0_low_write: assert property (s_write(fsk_hdr_pkg::ADDR_DELIM0_LOW) |=> o_search.pattern0[7:0] == $past(i_hwdata[7:0]))
    else $error("delimiter 0 low byte not taken");
  a_raw_len_high: assert property (s_write(fsk_hdr_pkg::ADDR_RAW_LEN_HIGH) |=> o_rx_cfg.raw_rx_len[10:8] == $past(i_hwdata[2:0]))
    else $error("raw length high bits not taken");
  a_dirmod_off: assert property (s_take(fsk_hdr_pkg::ADDR_DIRMOD, 1'b1) ##1 !i_hwdata[0] |=> !o_dirmod.dirmod_active && !o_dirmod.preemph_active)
    else $error("direct modulation active without baseband enable");
  a_rx_status_read: assert property (s_take(fsk_hdr_pkg::ADDR_RX_HDR, 1'b0) |=> o_hrdata == {24'h000000, $past(exp_rx_ff)})
    else $error("receive status read wrong");
endmodule
bind fsk_sfd_phr_config fsk_sfd_phr_config_monitor u_mon (.i_clk, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
  .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_rx_frame_start_irq, .i_rx_hdr, .o_search,
  .o_tx_cfg, .o_rx_cfg, .o_dirmod);
`default_nettype wire

// ===== hdl/fsk_sfd_phr_config.sv
// FSK delimiter search, header and direct-modulation configuration behind an AHB-Lite slave
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`default_nettype none
// What this block does
// - Hard decisions during delimiter search when set
// - Width bit 0: two 16-bit delimiters searched
// - Width bit 1: one 32-bit delimiter, ordered
// - Raw mode bit order follows reversal bit
// - Bits 3:2 pick delimiter-1 frame format
// - Bits 1:0 pick delimiter-0 frame format
// - Preamble length is 10 bits, octets
// - Delimiters held as low/high bytes
// - Transmit select chooses delimiter 0 or 1
// - Whitening bit enables whitening, sent in header
// - Two reserved header bits transmitted as written
// - Receive status updates on frame start
// - Checksum-type status copies header FCS bit
// - Mode-switch status at bit 6 copies header mode-switch flag
// - Delimiter status shows detected delimiter
// - Whitening status copies header bit
// - Reserved status bits copy header bits
// - Raw receive length is 11 bits
// - Direct modulation needs both enables
// - Preemphasis ignored without baseband enable
// - Three 8-bit preemphasis registers
// - Preamble high bits sit at 7:6
module fsk_sfd_phr_config (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_srst, // Synchronous reset, active high
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB bus ready
  output logic [31:0] o_hrdata, // AHB read data
  output logic o_hreadyout, // AHB slave ready
  output logic o_hresp, // AHB response, always OKAY
  input wire logic i_rx_frame_start_irq, // Frame start pulse from receiver
  input wire fsk_hdr_pkg::rx_hdr_t i_rx_hdr, // Header fields of the frame
  output fsk_hdr_pkg::delim_search_t o_search, // Delimiter search settings
  output fsk_hdr_pkg::tx_frame_cfg_t o_tx_cfg, // Transmit frame settings
  output fsk_hdr_pkg::rx_frame_cfg_t o_rx_cfg, // Receive frame settings
  output fsk_hdr_pkg::dirmod_cfg_t o_dirmod // Direct modulation settings
);

  // Masked byte write helper, keeps read-only bits at zero
  function automatic logic [7:0] masked(input logic [7:0] wdata, input logic [7:0] mask);
    masked = wdata & mask;
  endfunction

  logic [7:0] frame_cfg_ff;
  logic [7:0] preamble_high_ff;
  logic [7:0] preamble_low_ff;
  logic [7:0] delim0_low_ff;
  logic [7:0] delim0_high_ff;
  logic [7:0] delim1_low_ff;
  logic [7:0] delim1_high_ff;
  logic [7:0] tx_hdr_ff;
  logic [7:0] rx_hdr_ff;
  logic [7:0] raw_len_low_ff;
  logic [7:0] raw_len_high_ff;
  logic [7:0] dirmod_ff;
  logic [7:0] preemph0_ff;
  logic [7:0] preemph1_ff;
  logic [7:0] preemph2_ff;
  logic [7:0] tx_frontend_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic addr_phase;
  logic wr_en;

  // Zero-wait slave: every transfer completes in its data phase
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_ff;
  assign addr_phase = i_hsel && i_hready && (i_htrans == fsk_hdr_pkg::HTRANS_NONSEQ);
  assign wr_en = wr_pend_ff;

  // Capture write address phase; data arrives one cycle later
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (i_hready) begin
      wr_pend_ff <= addr_phase && i_hwrite && (i_hsize == fsk_hdr_pkg::HSIZE_WORD);
      wr_addr_ff <= i_haddr[7:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (i_haddr[7:0])
      fsk_hdr_pkg::ADDR_FRAME_CFG: nxt_rdata[7:0] = frame_cfg_ff;
      fsk_hdr_pkg::ADDR_PREAMBLE_HIGH: nxt_rdata[7:0] = preamble_high_ff;
      fsk_hdr_pkg::ADDR_PREAMBLE_LOW: nxt_rdata[7:0] = preamble_low_ff;
      fsk_hdr_pkg::ADDR_DELIM0_LOW: nxt_rdata[7:0] = delim0_low_ff;
      fsk_hdr_pkg::ADDR_DELIM0_HIGH: nxt_rdata[7:0] = delim0_high_ff;
      fsk_hdr_pkg::ADDR_DELIM1_LOW: nxt_rdata[7:0] = delim1_low_ff;
      fsk_hdr_pkg::ADDR_DELIM1_HIGH: nxt_rdata[7:0] = delim1_high_ff;
      fsk_hdr_pkg::ADDR_TX_HDR: nxt_rdata[7:0] = tx_hdr_ff;
      fsk_hdr_pkg::ADDR_RX_HDR: nxt_rdata[7:0] = rx_hdr_ff;
      fsk_hdr_pkg::ADDR_RAW_LEN_LOW: nxt_rdata[7:0] = raw_len_low_ff;
      fsk_hdr_pkg::ADDR_RAW_LEN_HIGH: nxt_rdata[7:0] = raw_len_high_ff;
      fsk_hdr_pkg::ADDR_DIRMOD: nxt_rdata[7:0] = dirmod_ff;
      fsk_hdr_pkg::ADDR_PREEMPH0: nxt_rdata[7:0] = preemph0_ff;
      fsk_hdr_pkg::ADDR_PREEMPH1: nxt_rdata[7:0] = preemph1_ff;
      fsk_hdr_pkg::ADDR_PREEMPH2: nxt_rdata[7:0] = preemph2_ff;
      fsk_hdr_pkg::ADDR_TX_FRONTEND: nxt_rdata[7:0] = tx_frontend_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (addr_phase && !i_hwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Search and framing configuration
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      frame_cfg_ff <= fsk_hdr_pkg::RST_FRAME_CFG;
      preamble_high_ff <= fsk_hdr_pkg::RST_PREAMBLE_HIGH;
      preamble_low_ff <= fsk_hdr_pkg::RST_PREAMBLE_LOW;
    end else if (wr_en) begin
      case (wr_addr_ff)
        fsk_hdr_pkg::ADDR_FRAME_CFG: frame_cfg_ff <= masked(i_hwdata[7:0], fsk_hdr_pkg::MASK_FRAME_CFG);
        fsk_hdr_pkg::ADDR_PREAMBLE_HIGH: preamble_high_ff <= masked(i_hwdata[7:0], fsk_hdr_pkg::MASK_PREAMBLE_HIGH);
        fsk_hdr_pkg::ADDR_PREAMBLE_LOW: preamble_low_ff <= i_hwdata[7:0];
        default: frame_cfg_ff <= frame_cfg_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      delim0_low_ff <= fsk_hdr_pkg::RST_DELIM0_LOW;
      delim0_high_ff <= fsk_hdr_pkg::RST_DELIM0_HIGH;
      delim1_low_ff <= fsk_hdr_pkg::RST_DELIM1_LOW;
      delim1_high_ff <= fsk_hdr_pkg::RST_DELIM1_HIGH;
    end else if (wr_en) begin
      case (wr_addr_ff)
        fsk_hdr_pkg::ADDR_DELIM0_LOW: delim0_low_ff <= i_hwdata[7:0];
        fsk_hdr_pkg::ADDR_DELIM0_HIGH: delim0_high_ff <= i_hwdata[7:0];
        fsk_hdr_pkg::ADDR_DELIM1_LOW: delim1_low_ff <= i_hwdata[7:0];
        fsk_hdr_pkg::ADDR_DELIM1_HIGH: delim1_high_ff <= i_hwdata[7:0];
        default: delim0_low_ff <= delim0_low_ff;
      endcase
    end
  end

  // Transmit header, raw length, direct modulation and preemphasis
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_hdr_ff <= fsk_hdr_pkg::RST_TX_HDR;
      raw_len_low_ff <= fsk_hdr_pkg::RST_GENERIC;
      raw_len_high_ff <= fsk_hdr_pkg::RST_GENERIC;
      dirmod_ff <= fsk_hdr_pkg::RST_GENERIC;
      preemph0_ff <= fsk_hdr_pkg::RST_GENERIC;
      preemph1_ff <= fsk_hdr_pkg::RST_GENERIC;
      preemph2_ff <= fsk_hdr_pkg::RST_GENERIC;
      tx_frontend_ff <= fsk_hdr_pkg::RST_GENERIC;
    end else if (wr_en) begin
      case (wr_addr_ff)
        fsk_hdr_pkg::ADDR_TX_HDR: tx_hdr_ff <= masked(i_hwdata[7:0], fsk_hdr_pkg::MASK_TX_HDR);
        fsk_hdr_pkg::ADDR_RAW_LEN_LOW: raw_len_low_ff <= i_hwdata[7:0];
        fsk_hdr_pkg::ADDR_RAW_LEN_HIGH: raw_len_high_ff <= masked(i_hwdata[7:0], fsk_hdr_pkg::MASK_RAW_LEN_HIGH);
        fsk_hdr_pkg::ADDR_DIRMOD: dirmod_ff <= masked(i_hwdata[7:0], fsk_hdr_pkg::MASK_DIRMOD);
        fsk_hdr_pkg::ADDR_PREEMPH0: preemph0_ff <= i_hwdata[7:0];
        fsk_hdr_pkg::ADDR_PREEMPH1: preemph1_ff <= i_hwdata[7:0];
        fsk_hdr_pkg::ADDR_PREEMPH2: preemph2_ff <= i_hwdata[7:0];
        // software keeps this bit legal; stored as written
        fsk_hdr_pkg::ADDR_TX_FRONTEND: tx_frontend_ff <= i_hwdata[7:0];
        default: tx_hdr_ff <= tx_hdr_ff;
      endcase
    end
  end

  // status captured on frame start only; register is read-only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_hdr_ff <= fsk_hdr_pkg::RST_RX_HDR;
    end else if (i_rx_frame_start_irq) begin
      rx_hdr_ff[fsk_hdr_pkg::POS_RX_CHECKSUM] <= i_rx_hdr.rx_checksum_type;
      rx_hdr_ff[fsk_hdr_pkg::POS_RX_MODE_SW] <= i_rx_hdr.rx_mode_switch_flag;
      rx_hdr_ff[5:4] <= 2'h0;
      rx_hdr_ff[fsk_hdr_pkg::POS_TX_DELIM_SEL] <= i_rx_hdr.rx_delim_detected;
      // whitening copied, meaningless in raw mode
      rx_hdr_ff[fsk_hdr_pkg::POS_TX_WHITEN] <= i_rx_hdr.rx_whitening_flag;
      rx_hdr_ff[fsk_hdr_pkg::POS_RSV_BIT2] <= i_rx_hdr.reserved_hdr_bit2;
      rx_hdr_ff[fsk_hdr_pkg::POS_RSV_BIT1] <= i_rx_hdr.reserved_hdr_bit1;
    end
  end

  // Search outputs
  always_comb begin
    o_search.hard_decision = frame_cfg_ff[fsk_hdr_pkg::POS_HARD_DECISION];
    // two 16-bit patterns, used when narrow
    o_search.wide_search = frame_cfg_ff[fsk_hdr_pkg::POS_WIDE_SEARCH];
    o_search.pattern0 = {delim0_high_ff, delim0_low_ff};
    o_search.pattern1 = {delim1_high_ff, delim1_low_ff};
    // wide pattern, delimiter 1 on top, sent LSB first
    o_search.pattern_wide = {delim1_high_ff, delim1_low_ff, delim0_high_ff, delim0_low_ff};
  end

  // Transmit framing outputs
  always_comb begin
    // 10-bit preamble length, high bits from 7:6
    o_tx_cfg.preamble_len = {preamble_high_ff[7:fsk_hdr_pkg::POS_PREAMBLE_HIGH], preamble_low_ff};
    o_tx_cfg.delim_select = tx_hdr_ff[fsk_hdr_pkg::POS_TX_DELIM_SEL];
    o_tx_cfg.delim_pattern = o_tx_cfg.delim_select ? o_search.pattern1 : o_search.pattern0;
    o_tx_cfg.fmt = o_tx_cfg.delim_select ? o_rx_cfg.fmt_delim1 : o_rx_cfg.fmt_delim0;
    o_tx_cfg.whitening_on = tx_hdr_ff[fsk_hdr_pkg::POS_TX_WHITEN];
    o_tx_cfg.reserved_hdr_bit2 = tx_hdr_ff[fsk_hdr_pkg::POS_RSV_BIT2];
    o_tx_cfg.reserved_hdr_bit1 = tx_hdr_ff[fsk_hdr_pkg::POS_RSV_BIT1];
    o_tx_cfg.raw_msb_first = o_rx_cfg.raw_msb_first;
  end

  // Receive framing outputs
  always_comb begin
    o_rx_cfg.fmt_delim0 = fsk_hdr_pkg::frame_fmt_t'(frame_cfg_ff[fsk_hdr_pkg::POS_FMT_DELIM0 +: 2]);
    o_rx_cfg.fmt_delim1 = fsk_hdr_pkg::frame_fmt_t'(frame_cfg_ff[fsk_hdr_pkg::POS_FMT_DELIM1 +: 2]);
    o_rx_cfg.raw_msb_first = frame_cfg_ff[fsk_hdr_pkg::POS_RAW_MSB_FIRST];
    o_rx_cfg.raw_rx_len = {raw_len_high_ff[2:0], raw_len_low_ff};
  end

  // Direct modulation gating
  always_comb begin
    o_dirmod.dirmod_active = dirmod_ff[fsk_hdr_pkg::POS_BB_DIRMOD_EN] && tx_frontend_ff[fsk_hdr_pkg::POS_FE_DIRMOD_EN];
    o_dirmod.preemph_active = dirmod_ff[fsk_hdr_pkg::POS_PREEMPH_EN] && dirmod_ff[fsk_hdr_pkg::POS_BB_DIRMOD_EN];
    o_dirmod.preemph_byte0 = preemph0_ff;
    o_dirmod.preemph_byte1 = preemph1_ff;
    o_dirmod.preemph_byte2 = preemph2_ff;
  end

endmodule
`default_nettype wire

// ===== include/fsk_hdr_pkg.sv
// Package: register map, field layout, reset values and carriers for the FSK header config block
`default_nettype none
package fsk_hdr_pkg;
  // Register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_FRAME_CFG = 8'h00;
  localparam logic [7:0] ADDR_PREAMBLE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_PREAMBLE_LOW = 8'h08;
  localparam logic [7:0] ADDR_DELIM0_LOW = 8'h0C;
  localparam logic [7:0] ADDR_DELIM0_HIGH = 8'h10;
  localparam logic [7:0] ADDR_DELIM1_LOW = 8'h14;
  localparam logic [7:0] ADDR_DELIM1_HIGH = 8'h18;
  localparam logic [7:0] ADDR_TX_HDR = 8'h1C;
  localparam logic [7:0] ADDR_RX_HDR = 8'h20;
  localparam logic [7:0] ADDR_RAW_LEN_LOW = 8'h24;
  localparam logic [7:0] ADDR_RAW_LEN_HIGH = 8'h28;
  localparam logic [7:0] ADDR_DIRMOD = 8'h2C;
  localparam logic [7:0] ADDR_PREEMPH0 = 8'h30;
  localparam logic [7:0] ADDR_PREEMPH1 = 8'h34;
  localparam logic [7:0] ADDR_PREEMPH2 = 8'h38;
  localparam logic [7:0] ADDR_TX_FRONTEND = 8'h3C;

  // Field positions in the frame config register
  localparam int POS_HARD_DECISION = 6;
  localparam int POS_WIDE_SEARCH = 5;
  localparam int POS_RAW_MSB_FIRST = 4;
  localparam int POS_FMT_DELIM1 = 2;
  localparam int POS_FMT_DELIM0 = 0;
  // Preamble-high field in its own register, bits 7:6
  localparam int POS_PREAMBLE_HIGH = 6;
  // Transmit header register
  localparam int POS_TX_DELIM_SEL = 3;
  localparam int POS_TX_WHITEN = 2;
  localparam int POS_RSV_BIT2 = 1;
  localparam int POS_RSV_BIT1 = 0;
  // Receive header status register
  localparam int POS_RX_CHECKSUM = 7;
  localparam int POS_RX_MODE_SW = 6;
  // Direct modulation register
  localparam int POS_PREEMPH_EN = 1;
  localparam int POS_BB_DIRMOD_EN = 0;
  // Frontend register
  localparam int POS_FE_DIRMOD_EN = 4;

  // Writable-bit masks
  localparam logic [7:0] MASK_FRAME_CFG = 8'h7F;
  localparam logic [7:0] MASK_PREAMBLE_HIGH = 8'hC0;
  localparam logic [7:0] MASK_TX_HDR = 8'h0F;
  localparam logic [7:0] MASK_RAW_LEN_HIGH = 8'h07;
  localparam logic [7:0] MASK_DIRMOD = 8'h03;

  // Reset values
  localparam logic [7:0] RST_FRAME_CFG = 8'h18;
  localparam logic [7:0] RST_PREAMBLE_HIGH = 8'h00;
  localparam logic [7:0] RST_PREAMBLE_LOW = 8'h00;
  localparam logic [7:0] RST_DELIM0_LOW = 8'h00;
  localparam logic [7:0] RST_DELIM0_HIGH = 8'h72;
  localparam logic [7:0] RST_DELIM1_LOW = 8'h00;
  localparam logic [7:0] RST_DELIM1_HIGH = 8'h00;
  localparam logic [7:0] RST_TX_HDR = 8'h04;
  localparam logic [7:0] RST_RX_HDR = 8'h00;
  localparam logic [7:0] RST_GENERIC = 8'h00;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Frame format codes per delimiter
  typedef enum logic [1:0] {
    FMT_UNCODED_IEEE = 2'b00,
    FMT_UNCODED_RAW = 2'b01,
    FMT_CODED_IEEE = 2'b10,
    FMT_CODED_RAW = 2'b11
  } frame_fmt_t;

  // Settings handed to the delimiter search
  typedef struct packed {
    logic hard_decision;
    logic wide_search;
    logic [15:0] pattern0;
    logic [15:0] pattern1;
    logic [31:0] pattern_wide;
  } delim_search_t;

  // Settings handed to the transmitter
  typedef struct packed {
    logic [9:0] preamble_len;
    logic delim_select;
    logic [15:0] delim_pattern;
    frame_fmt_t fmt;
    logic whitening_on;
    logic reserved_hdr_bit2;
    logic reserved_hdr_bit1;
    logic raw_msb_first;
  } tx_frame_cfg_t;

  // Header fields seen by the receiver at frame start
  typedef struct packed {
    logic rx_checksum_type;
    logic rx_mode_switch_flag;
    logic rx_delim_detected;
    logic rx_whitening_flag;
    logic reserved_hdr_bit2;
    logic reserved_hdr_bit1;
  } rx_hdr_t;

  // Receive framing settings
  typedef struct packed {
    frame_fmt_t fmt_delim0;
    frame_fmt_t fmt_delim1;
    logic raw_msb_first;
    logic [10:0] raw_rx_len;
  } rx_frame_cfg_t;

  // Direct modulation outputs
  typedef struct packed {
    logic dirmod_active;
    logic preemph_active;
    logic [7:0] preemph_byte0;
    logic [7:0] preemph_byte1;
    logic [7:0] preemph_byte2;
  } dirmod_cfg_t;
endpackage
`default_nettype wire
